// ===== hdl/mdie_pkg.sv
package mdie_pkg;
   // ==========================================================
   // register map on the core data bus
   localparam logic [15:0] CORE_LINE_MASK_ADDR     = 16'h0004;
   localparam logic [15:0] CORE_LINE_FLAGS_ADDR    = 16'h0006;
   localparam logic [15:0] DEVICE_IDENTIFIER_ADDR  = 16'h701C;
   localparam logic [15:0] DEVICE_IDENTIFIER_VALUE = 16'h5A01; // arbitrary value
   localparam logic [5:0]  CORE_LINE_MASK_RESET    = 6'h00;
   localparam logic [5:0]  CORE_LINE_FLAGS_RESET   = 6'h00;

   // ==========================================================
   // branch vectors
   localparam logic [15:0] RESET_VECTOR    = 16'h0000;
   localparam logic [15:0] TRAP_VECTOR     = 16'h0022;
   localparam logic [15:0] NMI_VECTOR      = 16'h0024;
   localparam logic [15:0] EMU_TRAP_VECTOR = 16'h0026;

   // ==========================================================
   // program and data space windows
   localparam logic [15:0] BOOT_ROM_LO    = 16'h0000;
   localparam logic [15:0] BOOT_ROM_HI    = 16'h00FF;
   localparam logic [15:0] PASSWORD_LO    = 16'h0040;
   localparam logic [15:0] PASSWORD_HI    = 16'h0043;
   localparam logic [15:0] PROG_B0_ALT_LO = 16'hFE00;
   localparam logic [15:0] PROG_B0_ALT_HI = 16'hFEFF;
   localparam logic [15:0] PROG_B0_LO     = 16'hFF00;
   localparam logic [15:0] PROG_B0_HI     = 16'hFFFF;
   localparam logic [15:0] DATA_B0_ALT_LO = 16'h0100;
   localparam logic [15:0] DATA_B0_ALT_HI = 16'h01FF;
   localparam logic [15:0] DATA_B0_LO     = 16'h0200;
   localparam logic [15:0] DATA_B0_HI     = 16'h02FF;
   localparam logic [15:0] DATA_B1_LO     = 16'h0300;
   localparam logic [15:0] DATA_B1_HI     = 16'h03FF;
   localparam logic [15:0] DATA_B1_ALT_LO = 16'h0400;
   localparam logic [15:0] DATA_B1_ALT_HI = 16'h04FF;

   // illegal data/peripheral ranges, lo/hi pairs
   localparam int ILLEGAL_COUNT = 8;
   localparam logic [15:0] ILLEGAL_LO [ILLEGAL_COUNT] = '{16'h0080, 16'h0500, 16'h0A00,
      16'h7030, 16'h7080, 16'h70C0, 16'h7440, 16'h7800};
   localparam logic [15:0] ILLEGAL_HI [ILLEGAL_COUNT] = '{16'h00FF, 16'h07FF, 16'h6FFF,
      16'h703F, 16'h708F, 16'h70FF, 16'h74FF, 16'hFFFF};

   // ==========================================================
   // expander sources: index order is priority order (0 highest)
   localparam int SRC_COUNT   = 18;
   localparam int PIN_PROTECT = 0;
   localparam int PIN_ONE     = 2;
   localparam int PIN_TWO     = 3;
   localparam logic [2:0] SRC_GROUP [SRC_COUNT] = '{3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0,
      3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd1, 3'd2, 3'd2, 3'd2, 3'd2, 3'd3};
   localparam logic [15:0] SRC_VECTOR [SRC_COUNT] = '{16'h0020, 16'h0004, 16'h0001,
      16'h0011, 16'h0006, 16'h0007, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028,
      16'h0029, 16'h002A, 16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0033};

   typedef enum logic [1:0] {PROG_MAIN, PROG_BOOT_ROM, PROG_BLOCK_ZERO, PROG_RESERVED} mdie_prog_t;
   typedef enum logic [2:0] {DATA_OTHER, DATA_BLOCK_ZERO, DATA_BLOCK_ONE, DATA_RESERVED,
      DATA_ILLEGAL} mdie_data_t;
endpackage

// ===== hdl/mdie_top.sv
`timescale 1ns/10ps
module mdie_top
   import mdie_pkg::*;
(
   input  wire logic                 ref_clk,               // 25 MHz clock
   input  wire logic                 sys_rst,               // synchronous reset
   input  wire logic                 resetPin,              // external reset pin
   input  wire logic                 watchdogTimeout,       // watchdog expiry pulse
   input  wire logic                 extPinRequestOne,      // pin request one
   input  wire logic                 extPinRequestTwo,      // pin request two
   input  wire logic                 powerStageProtect,     // protect pin request
   input  wire logic [2:0]           extPinEnable,          // protect, one, two enables
   input  wire logic [SRC_COUNT-1:0] periphEvent,           // peripheral event pulses
   input  wire logic [SRC_COUNT-1:0] periphEventEnable,     // per-event enables
   input  wire logic                 swIntrExec,            // software interrupt instr
   input  wire logic [15:0]          swIntrVector,          // its operand vector
   input  wire logic                 nmiInstrExec,          // nonmaskable instr
   input  wire logic                 trapInstrExec,         // trap instr
   input  wire logic                 trapToEmulator,        // trap selects emulator
   input  wire logic                 maskableEnableExec,    // clear global disable
   input  wire logic                 ackValid,              // core acknowledges a line
   input  wire logic [2:0]           ackLine,               // acknowledged line 0..5
   input  wire logic                 ramBlockZeroPlacement, // block zero placement bit
   input  wire logic                 bootRomEnable,         // boot ROM overlay on
   input  wire logic                 progValid,             // program fetch/access
   input  wire logic [15:0]          progAddr,              // program address
   input  wire logic                 dataValid,             // data space access
   input  wire logic [15:0]          dataAddr,              // data address
   input  wire logic                 dataWrite,             // data write strobe
   input  wire logic [15:0]          dataWdata,             // data write value
   output logic [15:0]               dataRdata,             // register read value
   output logic                      deviceReset,           // reset to core, level
   output logic                      branchValid,           // branch request pulse
   output logic [15:0]               branchVector,          // branch target
   output logic                      globalMaskableDisable, // global disable flag
   output logic                      emulatorTrap,          // emulator trap pulse
   output logic [5:0]                coreRequestLines,      // six core lines
   output logic [5:0]                coreLineFlags,         // pending line flags
   output logic [15:0]               peripheralVectorRegister, // last acked vector
   output logic                      passwordAccess,        // password word touched
   output mdie_prog_t                progTarget,            // program decode result
   output logic [7:0]                progOffset,            // word in target block
   output mdie_data_t                dataTarget,            // data decode result
   output logic [7:0]                dataOffset             // word in target block
);

   // ==========================================================
   // helpers
   function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
      inRange = (a >= lo) && (a <= hi);
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [3:0] pinMeta;
   logic [3:0] pinSync;
   logic [2:0] pinLast;

   // two flops before any logic reads the pins
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pinMeta <= 4'h0;
         pinSync <= 4'h0;
      end
      else
      begin
         pinMeta <= {resetPin, powerStageProtect, extPinRequestTwo, extPinRequestOne};
         pinSync <= pinMeta;
      end
   end

   // ==========================================================
   // reset gathering
   logic resetEvent;

   assign resetEvent = pinSync[3] | watchdogTimeout;

   // reset level to the core, unarbitrated
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         deviceReset <= 1'b1;
      else
         deviceReset <= resetEvent;
   end

   // ==========================================================
   // expander source requests
   logic [SRC_COUNT-1:0] srcRaw;
   logic [SRC_COUNT-1:0] srcPending;
   logic [SRC_COUNT-1:0] ackClear;
   logic [5:0]           groupAny;
   logic [15:0]          ackVector;
   logic                 ackHit;

   // pin edges with dedicated enables, events with per-event enables
   always_comb
   begin
      srcRaw = periphEvent & periphEventEnable;
      srcRaw[PIN_ONE] = pinSync[0] & ~pinLast[0] & extPinEnable[1];
      srcRaw[PIN_TWO] = pinSync[1] & ~pinLast[1] & extPinEnable[2];
      srcRaw[PIN_PROTECT] = pinSync[2] & ~pinLast[2] & extPinEnable[0];
   end

   // pick highest-priority pending source of the acked group
   always_comb
   begin
      ackClear  = '0;
      ackVector = 16'h0000;
      ackHit    = 1'b0;
      for (int i = SRC_COUNT - 1; i >= 0; i--)
      begin
         if (ackValid && srcPending[i] && (SRC_GROUP[i] == ackLine))
         begin
            ackClear  = '0;
            ackClear[i] = 1'b1;
            ackVector = SRC_VECTOR[i];
            ackHit    = 1'b1;
         end
      end
   end

   // group lines: any pending member
   always_comb
   begin
      groupAny = 6'h00;
      for (int i = 0; i < SRC_COUNT; i++)
         groupAny[SRC_GROUP[i]] = groupAny[SRC_GROUP[i]] | srcPending[i];
   end

   // pin edge history
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         pinLast <= 3'h0;
      else
         pinLast <= pinSync[2:0];
   end

   // pending sources, new request wins over ack clear
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || resetEvent)
         srcPending <= '0;
      else
         srcPending <= (srcPending & ~ackClear) | srcRaw;
   end

   // vector register
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || resetEvent)
         peripheralVectorRegister <= 16'h0000;
      else if (ackHit)
         peripheralVectorRegister <= ackVector;
   end

   // ==========================================================
   // core line mask and flags
   logic [5:0] coreLineMask;
   logic       maskWrite;
   logic       flagWrite;

   assign maskWrite = dataValid && dataWrite && (dataAddr == CORE_LINE_MASK_ADDR);
   assign flagWrite = dataValid && dataWrite && (dataAddr == CORE_LINE_FLAGS_ADDR);

   // mask cleared by every reset
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || resetEvent)
         coreLineMask <= CORE_LINE_MASK_RESET;
      else if (maskWrite)
         coreLineMask <= dataWdata[5:0];
   end

   // flags: write one clears, a live group request wins
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || resetEvent)
         coreLineFlags <= CORE_LINE_FLAGS_RESET;
      else if (flagWrite)
         coreLineFlags <= (coreLineFlags & ~dataWdata[5:0]) | groupAny;
      else
         coreLineFlags <= groupAny;
   end

   // lines to the core gated by mask
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || resetEvent)
         coreRequestLines <= 6'h00;
      else
         coreRequestLines <= groupAny & coreLineMask;
   end

   // ==========================================================
   // register reads
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         dataRdata <= 16'h0000;
      else if (dataValid && !dataWrite)
      begin
         unique case (dataAddr)
            CORE_LINE_MASK_ADDR:    dataRdata <= {10'h000, coreLineMask};
            CORE_LINE_FLAGS_ADDR:   dataRdata <= {10'h000, coreLineFlags};
            DEVICE_IDENTIFIER_ADDR: dataRdata <= DEVICE_IDENTIFIER_VALUE;
            default:                dataRdata <= 16'h0000;
         endcase
      end
   end

   // ==========================================================
   // address decode
   logic illegalHit;

   always_comb
   begin
      illegalHit = 1'b0;
      for (int i = 0; i < ILLEGAL_COUNT; i++)
         illegalHit = illegalHit | inRange(dataAddr, ILLEGAL_LO[i], ILLEGAL_HI[i]);
   end

   // program space targets
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         progTarget     <= PROG_MAIN;
         progOffset     <= 8'h00;
         passwordAccess <= 1'b0;
      end
      else
      begin
         progOffset     <= progAddr[7:0]; // both block zero windows share the low byte
         passwordAccess <= progValid && inRange(progAddr, PASSWORD_LO, PASSWORD_HI);
         if (bootRomEnable && inRange(progAddr, BOOT_ROM_LO, BOOT_ROM_HI))
            progTarget <= PROG_BOOT_ROM;
         else if (inRange(progAddr, PASSWORD_LO, PASSWORD_HI))
            progTarget <= PROG_RESERVED;
         else if (inRange(progAddr, PROG_B0_LO, PROG_B0_HI) ||
                  inRange(progAddr, PROG_B0_ALT_LO, PROG_B0_ALT_HI))
            progTarget <= ramBlockZeroPlacement ? PROG_BLOCK_ZERO : PROG_RESERVED;
         else
            progTarget <= PROG_MAIN;
      end
   end

   // data space targets
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         dataTarget <= DATA_OTHER;
         dataOffset <= 8'h00;
      end
      else
      begin
         dataOffset <= dataAddr[7:0];
         if (inRange(dataAddr, DATA_B0_LO, DATA_B0_HI) ||
             inRange(dataAddr, DATA_B0_ALT_LO, DATA_B0_ALT_HI))
            dataTarget <= ramBlockZeroPlacement ? DATA_RESERVED : DATA_BLOCK_ZERO;
         else if (inRange(dataAddr, DATA_B1_LO, DATA_B1_HI) ||
                  inRange(dataAddr, DATA_B1_ALT_LO, DATA_B1_ALT_HI))
            dataTarget <= DATA_BLOCK_ONE;
         else if (illegalHit)
            dataTarget <= DATA_ILLEGAL;
         else
            dataTarget <= DATA_OTHER;
      end
   end

   // ==========================================================
   // branch requests, reset first, then illegal access or nmi instr, then software interrupt, then trap
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         branchValid  <= 1'b0;
         branchVector <= RESET_VECTOR;
         emulatorTrap <= 1'b0;
      end
      else
      begin
         branchValid  <= resetEvent | (dataValid & illegalHit) | nmiInstrExec |
                         swIntrExec | trapInstrExec;
         emulatorTrap <= 1'b0;
         if (resetEvent)
            branchVector <= RESET_VECTOR;
         else if ((dataValid && illegalHit) || nmiInstrExec)
            branchVector <= NMI_VECTOR;
         else if (swIntrExec)
         begin
            branchVector <= swIntrVector;
            emulatorTrap <= (swIntrVector == EMU_TRAP_VECTOR);
         end
         else if (trapInstrExec)
         begin
            branchVector <= trapToEmulator ? EMU_TRAP_VECTOR : TRAP_VECTOR;
            emulatorTrap <= trapToEmulator;
         end
      end
   end

   // global disable: set by reset and disabling branches, trap leaves it
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || resetEvent)
         globalMaskableDisable <= 1'b1;
      else if ((dataValid && illegalHit) || nmiInstrExec || swIntrExec)
         globalMaskableDisable <= 1'b1;
      else if (maskableEnableExec && !trapInstrExec)
         globalMaskableDisable <= 1'b0;
   end

endmodule // mdie_top

// ===== sim/mdie_checker.sv
`timescale 1ns/10ps
module mdie_checker
   import mdie_pkg::*;
(
   input wire logic       ref_clk,               // clock
   input wire logic       sys_rst,               // reset
   input wire logic       watchdogTimeout,       // watchdog expiry
   input wire logic       swIntrExec,            // software interrupt
   input wire logic [15:0] swIntrVector,         // its operand
   input wire logic       nmiInstrExec,          // nonmaskable instr
   input wire logic       trapInstrExec,         // trap instr
   input wire logic       trapToEmulator,        // emulator select
   input wire logic       ramBlockZeroPlacement, // placement bit
   input wire logic       bootRomEnable,         // boot overlay
   input wire logic       progValid,             // program access
   input wire logic [15:0] progAddr,             // program address
   input wire logic       dataValid,             // data access
   input wire logic [15:0] dataAddr,             // data address
   input wire logic       dataWrite,             // write strobe
   input wire logic [15:0] dataRdata,            // read value
   input wire logic       deviceReset,           // core reset
   input wire logic       branchValid,           // branch pulse
   input wire logic [15:0] branchVector,         // branch target
   input wire logic       globalMaskableDisable, // global disable
   input wire logic [5:0] coreRequestLines,      // core lines
   input wire mdie_prog_t progTarget,            // program decode
   input wire logic [7:0] progOffset,            // program offset
   input wire mdie_data_t dataTarget,            // data decode
   input wire logic [7:0] dataOffset             // data offset
);
   // ==========================================================
   // address history for decode checks
   logic [15:0] progAddrQ;
   logic [15:0] dataAddrQ;
   always_ff @(posedge ref_clk)
   begin
      progAddrQ <= progAddr;
      dataAddrQ <= dataAddr;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // properties
   a_wd_reset: assert property (watchdogTimeout |=> deviceReset ##[0:2]
      (branchValid && branchVector == RESET_VECTOR)) else $error("watchdog reset missing");
   a_reset_masks: assert property (deviceReset ##1 deviceReset |->
      globalMaskableDisable && coreRequestLines == 6'h00) else $error("lines open in reset");
   a_nmi_branch: assert property (nmiInstrExec && !watchdogTimeout |=> branchValid
      && branchVector == NMI_VECTOR && globalMaskableDisable) else $error("nmi branch wrong");
   a_software_interrupt_instruction_branch: assert property (swIntrExec && !nmiInstrExec && !watchdogTimeout
      && !dataValid |=> branchValid && branchVector == $past(swIntrVector)
      && globalMaskableDisable) else $error("software_interrupt_instruction branch wrong");
   a_trap_keeps: assert property (trapInstrExec && !swIntrExec && !nmiInstrExec
      && !watchdogTimeout && !dataValid |=> branchValid && $stable(globalMaskableDisable)
      && branchVector == ($past(trapToEmulator) ? EMU_TRAP_VECTOR : TRAP_VECTOR))
      else $error("trap branch wrong");
   a_boot_decode: assert property (progValid && bootRomEnable
      && progAddr <= BOOT_ROM_HI
      |=> progTarget == PROG_BOOT_ROM && progOffset == progAddrQ[7:0]) else $error("boot decode");
   a_prog_alias: assert property (progValid && ramBlockZeroPlacement
      && progAddr >= PROG_B0_ALT_LO |=> progTarget == PROG_BLOCK_ZERO
      && progOffset == progAddrQ[7:0]) else $error("program alias");
   a_data_b1: assert property (dataValid
      && dataAddr inside {[DATA_B1_LO:DATA_B1_ALT_HI]}
      |=> dataTarget == DATA_BLOCK_ONE && dataOffset == dataAddrQ[7:0]) else $error("block one");
   a_illegal_nmi: assert property (dataValid && !watchdogTimeout
      && dataAddr inside {[16'h0500:16'h07FF]} |=> dataTarget == DATA_ILLEGAL
      && branchValid && branchVector == NMI_VECTOR) else $error("illegal access");
   a_id_read: assert property (dataValid && !dataWrite
      && dataAddr == DEVICE_IDENTIFIER_ADDR
      |=> dataRdata == DEVICE_IDENTIFIER_VALUE) else $error("identifier read");

   c_line: cover property (coreRequestLines != 6'h00);
   c_nmi: cover property (branchValid && branchVector == NMI_VECTOR);
   c_reset: cover property (deviceReset);
endmodule // mdie_checker

bind mdie_top mdie_checker i_chk (.ref_clk, .sys_rst, .watchdogTimeout, .swIntrExec,
   .swIntrVector, .nmiInstrExec, .trapInstrExec, .trapToEmulator, .ramBlockZeroPlacement,
   .bootRomEnable, .progValid, .progAddr, .dataValid, .dataAddr, .dataWrite, .dataRdata,
   .deviceReset, .branchValid, .branchVector, .globalMaskableDisable, .coreRequestLines,
   .progTarget, .progOffset, .dataTarget, .dataOffset);

// ===== sim/mdie_core_model.sv
`timescale 1ns/10ps
module mdie_core_model (
   input  wire logic [0:0] ref_clk,          // clock
   input  wire logic       sys_rst,          // reset
   input  wire logic [3:0] ackWait,          // cycles before acknowledge
   input  wire logic [5:0] coreRequestLines, // lines from the block
   output logic            ackValid,         // acknowledge pulse
   output logic [2:0]      ackLine           // acknowledged line
);
   logic [3:0] waitCnt;
   logic [2:0] pick;

   // lowest raised line is served first
   always_comb
   begin
      pick = 3'h0;
      for (int i = 5; i >= 0; i--)
         if (coreRequestLines[i])
            pick = 3'(i);
   end

   // acknowledge after a programmable wait, line bus inverted when idle
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ackValid <= 1'b0;
         ackLine  <= 3'h7;
         waitCnt  <= 4'h0;
      end
      else if (ackValid)
      begin
         ackValid <= 1'b0;
         ackLine  <= ~ackLine;
         waitCnt  <= 4'h0;
      end
      else if (coreRequestLines != 6'h00 && waitCnt >= ackWait)
      begin
         ackValid <= 1'b1;
         ackLine  <= pick;
      end
      else if (coreRequestLines != 6'h00)
         waitCnt <= waitCnt + 4'h1;
   end
endmodule // mdie_core_model

// ===== sim/memory_decode_interrupt_expansion_test.sv
`timescale 1ns/10ps
module memory_decode_interrupt_expansion_test;
   import mdie_pkg::*;
   logic ref_clk, sys_rst, resetPin, watchdogTimeout, swIntrExec, nmiInstrExec;
   logic trapInstrExec, trapToEmulator, maskableEnableExec, ackValid, bootRomEnable;
   logic ramBlockZeroPlacement, progValid, dataValid, dataWrite, deviceReset;
   logic branchValid, globalMaskableDisable, emulatorTrap, passwordAccess;
   logic extPinRequestOne, extPinRequestTwo, powerStageProtect;
   logic [2:0]  extPinEnable, ackLine, pinReq;
   logic [3:0]  ackWait;
   logic [5:0]  coreRequestLines, coreLineFlags;
   logic [7:0]  progOffset, dataOffset;
   logic [15:0] swIntrVector, progAddr, dataAddr, dataWdata, dataRdata;
   logic [15:0] branchVector, peripheralVectorRegister;
   logic [SRC_COUNT-1:0] periphEvent, periphEventEnable;
   mdie_prog_t  progTarget;
   mdie_data_t  dataTarget;
   int          error_cnt;
   int          total_checks;

   assign {extPinRequestTwo, extPinRequestOne, powerStageProtect} = pinReq;
   mdie_top i_dut (.*);
   mdie_core_model i_core (.ref_clk, .sys_rst, .ackWait, .coreRequestLines, .ackValid,
      .ackLine);

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] act, input logic [15:0] exp);
      total_checks++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic acc(input logic [15:0] a, input logic wr, input logic [15:0] d);
      {dataValid, dataWrite, dataAddr, dataWdata} = {1'b1, wr, a, d};
      cyc(1);
   endtask
   task automatic rest();
      {dataValid, dataWrite, progValid} = 3'h0;
      cyc(2);
   endtask
   task automatic waitLine(input int b, input logic lvl);
      int n;
      n = 0;
      while (coreRequestLines[b] !== lvl && n < 40)
      begin
         cyc(1);
         n++;
      end
      chk(16'(coreRequestLines[b]), 16'(lvl));
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      chk(16'(globalMaskableDisable), 16'h0001);
      acc(DEVICE_IDENTIFIER_ADDR, 1'b1, 16'h1234);
      acc(DEVICE_IDENTIFIER_ADDR, 1'b0, 16'h0000);
      chk(dataRdata, DEVICE_IDENTIFIER_VALUE);
      acc(16'h7010, 1'b0, 16'h0000);
      chk(dataRdata, 16'h0000);
      rest();
   endtask
   task automatic t_periph();
      ackWait = 4'h8;
      periphEventEnable = 18'h00A00;
      periphEvent = 18'h00E00;
      cyc(1);
      periphEvent = '0;
      cyc(3);
      chk(16'(coreRequestLines), 16'h0000);
      chk(16'(coreLineFlags), 16'h0002);
      // write-one-clear loses against a still pending group
      acc(CORE_LINE_FLAGS_ADDR, 1'b1, 16'h003F);
      acc(CORE_LINE_FLAGS_ADDR, 1'b0, 16'h0000);
      chk(dataRdata, 16'h0002);
      acc(CORE_LINE_MASK_ADDR, 1'b1, 16'hFFFF);
      acc(CORE_LINE_MASK_ADDR, 1'b0, 16'h0000);
      chk(dataRdata, 16'h003F);
      rest();
      waitLine(1, 1'b1);
      cyc(12);
      chk(peripheralVectorRegister, 16'h0027);
      waitLine(1, 1'b0);
      chk(peripheralVectorRegister, 16'h0029);
      cyc(20);
      chk(16'(coreRequestLines), 16'h0000);
   endtask
   task automatic t_pins();
      logic [15:0] pinVec [3];
      pinVec = '{SRC_VECTOR[PIN_PROTECT], SRC_VECTOR[PIN_ONE], SRC_VECTOR[PIN_TWO]};
      ackWait = 4'h0;
      for (int i = 0; i < 3; i++)
      begin
         extPinEnable = 3'h0;
         pinReq = 3'h1 << i;
         cyc(6);
         chk(16'(coreRequestLines), 16'h0000);
         pinReq = 3'h0;
         cyc(2);
         extPinEnable = 3'h1 << i;
         pinReq = 3'h1 << i;
         waitLine(0, 1'b1);
         waitLine(0, 1'b0);
         chk(peripheralVectorRegister, pinVec[i]);
         pinReq = 3'h0;
         cyc(2);
      end
   endtask
   task automatic t_branch();
      logic [15:0] vec [5];
      vec = '{16'h0033, NMI_VECTOR, TRAP_VECTOR, EMU_TRAP_VECTOR, EMU_TRAP_VECTOR};
      for (int k = 0; k < 5; k++)
      begin
         maskableEnableExec = 1'b1;
         cyc(1);
         maskableEnableExec = 1'b0;
         swIntrVector = (k == 4) ? EMU_TRAP_VECTOR : 16'h0033;
         swIntrExec = (k == 0 || k == 4);
         nmiInstrExec = (k == 1);
         trapInstrExec = (k == 2 || k == 3);
         trapToEmulator = (k == 3);
         cyc(1);
         {swIntrExec, nmiInstrExec, trapInstrExec} = 3'h0;
         chk(16'(branchValid), 16'h0001);
         chk(branchVector, vec[k]);
         chk(16'(globalMaskableDisable), 16'(k < 2 || k == 4));
         chk(16'(emulatorTrap), 16'(k > 2));
      end
   endtask
   task automatic t_decode();
      logic [15:0] tab [7][4];
      logic        d;
      tab = '{'{16'h3, 16'h0010, 16'(PROG_BOOT_ROM), 16'h0010},
         '{16'h2, 16'hFE05, 16'(PROG_BLOCK_ZERO), 16'h0005},
         '{16'h2, 16'hFF05, 16'(PROG_BLOCK_ZERO), 16'h0005},
         '{16'h4, 16'h0105, 16'(DATA_BLOCK_ZERO), 16'h0005},
         '{16'h4, 16'h0205, 16'(DATA_BLOCK_ZERO), 16'h0005},
         '{16'h4, 16'h0305, 16'(DATA_BLOCK_ONE), 16'h0005},
         '{16'h4, 16'h04A5, 16'(DATA_BLOCK_ONE), 16'h00A5}};
      for (int i = 0; i < 7; i++)
      begin
         d = tab[i][0][2];
         {ramBlockZeroPlacement, bootRomEnable} = tab[i][0][1:0];
         {progValid, progAddr} = {~d, tab[i][1]};
         {dataValid, dataAddr} = {d, tab[i][1]};
         cyc(1);
         chk(d ? 16'(dataTarget) : 16'(progTarget), tab[i][2]);
         chk(d ? 16'(dataOffset) : 16'(progOffset), tab[i][3]);
      end
      {progValid, dataValid, bootRomEnable, progAddr} = {3'h4, 16'h0041};
      cyc(1);
      chk(16'(progTarget), 16'(PROG_RESERVED));
      chk(16'(passwordAccess), 16'h0001);
      {progValid, dataValid, dataAddr} = {2'h1, 16'h0600};
      cyc(1);
      chk(branchVector, NMI_VECTOR);
      rest();
   endtask
   task automatic t_reset();
      int n;
      {watchdogTimeout, nmiInstrExec} = 2'h3;
      cyc(1);
      {watchdogTimeout, nmiInstrExec} = 2'h0;
      chk(16'(deviceReset), 16'h0001);
      n = 0;
      while (branchValid !== 1'b1 && n < 4)
      begin
         cyc(1);
         n++;
      end
      chk(branchVector, RESET_VECTOR);
      cyc(3);
      acc(CORE_LINE_MASK_ADDR, 1'b0, 16'h0000);
      chk(dataRdata, 16'(CORE_LINE_MASK_RESET));
      rest();
      resetPin = 1'b1;
      cyc(4);
      chk(16'(deviceReset), 16'h0001);
      resetPin = 1'b0;
      cyc(6);
      chk(16'(deviceReset), 16'h0000);
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      {resetPin, watchdogTimeout, swIntrExec, nmiInstrExec, trapInstrExec} = 5'h0;
      {trapToEmulator, maskableEnableExec, bootRomEnable, ramBlockZeroPlacement} = 4'h0;
      {progValid, dataValid, dataWrite, extPinEnable, pinReq, ackWait} = 13'h0;
      {swIntrVector, progAddr, dataAddr, dataWdata} = 64'h0;
      {periphEvent, periphEventEnable} = '0;
      sys_rst = 1'b1;
      cyc(20);
      sys_rst = 1'b0;
      cyc(2);
      t_regs();
      t_periph();
      t_pins();
      t_branch();
      t_decode();
      t_reset();
      end_sim();
   end
   initial
   begin
      #400000;
      error_cnt++;
      end_sim();
   end
endmodule // memory_decode_interrupt_expansion_test
